/* bench/test_core_mode_privilege_stack.sv */
// Purpose: self-checking bench for the mode, privilege and stack unit
// Assumes: instructions act at the fourth edge counting the taking edge
// Notes: inputs change 5 ns after the rising edge
`timescale 1ns/1ns
module test_core_mode_privilege_stack;
  import cmps_pkg::*;
  localparam logic [31:0] MAIN_SP_INIT = 32'h2000_0400;
  logic        clk_in, reset_in, instr_valid_in, exc_entry_in, exc_return_in;
  cmps_op_t    instr_op_in;
  logic [31:0] instr_data_in, dmem_rdata_in, dmem_addr_out, dmem_wdata_out;
  logic [31:0] main_sp_out, process_sp_out, sreg_data_out;
  logic [1:0]  control_out;
  logic        dmem_read_out, dmem_write_out, imem_fetch_out, handler_mode_out;
  logic        privileged_out, proc_stack_out, fault_out, svc_request_out;
  int          mismatches;
  int          n_tests;
  cmps_op_t    refused [4] = '{CMPS_OP_STATE_CHG, CMPS_OP_SREG_WR, CMPS_OP_SYS_ACC,
                               CMPS_OP_CTRL_WR};

  cmps_core dut (.clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
    .instr_op_in(instr_op_in), .instr_data_in(instr_data_in), .exc_entry_in(exc_entry_in),
    .exc_return_in(exc_return_in), .dmem_rdata_in(dmem_rdata_in),
    .dmem_read_out(dmem_read_out), .dmem_write_out(dmem_write_out),
    .dmem_addr_out(dmem_addr_out), .dmem_wdata_out(dmem_wdata_out),
    .imem_fetch_out(imem_fetch_out), .handler_mode_out(handler_mode_out),
    .privileged_out(privileged_out), .proc_stack_out(proc_stack_out),
    .control_out(control_out), .main_sp_out(main_sp_out), .process_sp_out(process_sp_out),
    .fault_out(fault_out), .svc_request_out(svc_request_out), .sreg_data_out(sreg_data_out));

  // ****************************************
  // clock, tasks
  // ****************************************
  always #25 clk_in = ~clk_in;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // present one instruction, return just after the edge its effects land on
  task automatic issue(input cmps_op_t op, input logic [31:0] data);
    @(posedge clk_in);
    #5;
    instr_valid_in = 1'b1;
    instr_op_in = op;
    instr_data_in = data;
    @(posedge clk_in);
    #5;
    instr_valid_in = 1'b0;
    instr_op_in = CMPS_OP_NONE;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic exc(input logic entry);
    @(posedge clk_in);
    #5;
    exc_entry_in = entry;
    exc_return_in = !entry;
    @(posedge clk_in);
    #5;
    exc_entry_in = 1'b0;
    exc_return_in = 1'b0;
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    repeat (2) @(posedge clk_in);
    #1;
    chk("ctrl_rst", 32'h0, {30'h0, control_out});
    #4;
    reset_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk("boot_read", 32'h1, {31'h0, dmem_read_out});
    chk("boot_addr", SP_VECTOR_ADDR, dmem_addr_out);
    @(posedge clk_in);
    #1;
    chk("main_sp_load", MAIN_SP_INIT, main_sp_out);
    chk("fetch", 32'h1, {31'h0, imem_fetch_out});
    chk("thread", 32'h0, {31'h0, handler_mode_out});
    $display("test reset done");
  endtask

  task automatic t_stacks;
    issue(CMPS_OP_PUSH, 32'hcafe_0001);
    chk("push_wr", 32'h1, {31'h0, dmem_write_out});
    chk("push_addr", MAIN_SP_INIT - WORD_BYTES, dmem_addr_out);
    chk("push_data", 32'hcafe_0001, dmem_wdata_out);
    issue(CMPS_OP_CTRL_WR, 32'h2);
    chk("proc_sel", 32'h1, {31'h0, proc_stack_out});
    issue(CMPS_OP_PUSH, 32'h5);
    chk("proc_push", SP_RESET - WORD_BYTES, process_sp_out);
    chk("main_kept", MAIN_SP_INIT - WORD_BYTES, main_sp_out);
    exc(1'b1);
    chk("handler", 32'h1, {31'h0, handler_mode_out});
    chk("hdl_main", 32'h0, {31'h0, proc_stack_out});
    issue(CMPS_OP_PUSH, 32'h7);
    chk("hdl_push", MAIN_SP_INIT - 2 * WORD_BYTES, dmem_addr_out);
    exc(1'b0);
    chk("ret_thread", 32'h0, {31'h0, handler_mode_out});
    chk("ret_proc", 32'h1, {31'h0, proc_stack_out});
    $display("test stacks done");
  endtask

  task automatic t_privilege;
    issue(CMPS_OP_CTRL_WR, 32'h3);
    chk("unpriv", 32'h0, {31'h0, privileged_out});
    foreach (refused[i]) begin
      issue(refused[i], 32'h0);
      chk("refuse", 32'h1, {31'h0, fault_out});
      chk("ctrl_kept", 32'h3, {30'h0, control_out});
    end
    issue(CMPS_OP_SREG_RD, 32'h0);
    chk("sreg_unpriv", 32'h0, sreg_data_out);
    issue(CMPS_OP_SUP_CALL, 32'h0);
    chk("sup_call", 32'h1, {31'h0, svc_request_out});
    exc(1'b1);
    chk("hdl_priv", 32'h1, {31'h0, privileged_out});
    issue(CMPS_OP_SREG_RD, 32'h0);
    chk("sreg_priv", 32'h3, sreg_data_out);
    issue(CMPS_OP_STATE_CHG, 32'h0);
    chk("state_chg_priv", 32'h0, {31'h0, fault_out});
    exc(1'b0);
    chk("back_unpriv", 32'h0, {31'h0, privileged_out});
    $display("test privilege done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    instr_valid_in = 1'b0;
    instr_op_in = CMPS_OP_NONE;
    instr_data_in = 32'h0;
    exc_entry_in = 1'b0;
    exc_return_in = 1'b0;
    dmem_rdata_in = MAIN_SP_INIT;
    mismatches = 0;
    n_tests = 0;
    t_reset();
    t_stacks();
    t_privilege();
    stop_test();
  end

  // about 77 cycles of work; allow 2000, some twenty-six times that
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule

/* src/cmps_core.sv */
// Purpose: execution mode, privilege and dual stack pointer control
// Assumes: inputs synchronous to clk_in; memory reads answer next cycle
// Notes: ops enter a three-stage pipe, act in the last stage
`timescale 1ns/1ns
module cmps_core (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        reset_in,
  // instruction stream
  input  wire logic                        instr_valid_in,
  input  wire cmps_pkg::cmps_op_t          instr_op_in,
  input  wire logic [cmps_pkg::DATA_W-1:0] instr_data_in,
  // exception controller
  input  wire logic                        exc_entry_in,
  input  wire logic                        exc_return_in,
  // data memory path
  input  wire logic [cmps_pkg::DATA_W-1:0] dmem_rdata_in,
  output logic                             dmem_read_out,
  output logic                             dmem_write_out,
  output logic [cmps_pkg::DATA_W-1:0]      dmem_addr_out,
  output logic [cmps_pkg::DATA_W-1:0]      dmem_wdata_out,
  // instruction path
  output logic                             imem_fetch_out,
  // status
  output logic                             handler_mode_out,
  output logic                             privileged_out,
  output logic                             proc_stack_out,
  output logic [1:0]                       control_out,
  output logic [cmps_pkg::DATA_W-1:0]      main_sp_out,
  output logic [cmps_pkg::DATA_W-1:0]      process_sp_out,
  output logic                             fault_out,
  output logic                             svc_request_out,
  output logic [cmps_pkg::DATA_W-1:0]      sreg_data_out
);
  import cmps_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  cmps_state_t              state,      next_state;
  logic [1:0]               ctrl,       next_ctrl;
  logic [DATA_W-1:0]        main_sp,    next_main_sp;
  logic [DATA_W-1:0]        proc_sp,    next_proc_sp;
  cmps_op_t                 pipe_op           [PIPE_STAGES];
  cmps_op_t                 next_pipe_op      [PIPE_STAGES];
  logic [DATA_W-1:0]        pipe_data         [PIPE_STAGES];
  logic [DATA_W-1:0]        next_pipe_data    [PIPE_STAGES];
  logic                     pipe_vld          [PIPE_STAGES];
  logic                     next_pipe_vld     [PIPE_STAGES];
  logic                     next_rd,    next_wr;
  logic [DATA_W-1:0]        next_addr,  next_wdata;
  logic                     next_fault, next_svc;
  logic [DATA_W-1:0]        next_sreg;
  logic                     in_handler, priv, use_proc;
  cmps_op_t                 ex_op;
  logic [DATA_W-1:0]        ex_data;
  logic                     ex_vld;
  logic [DATA_W-1:0]        sp_dec;

  // privilege and stack choice follow the mode and the control word
  assign in_handler = (state == CMPS_HANDLER);
  assign priv       = in_handler || !ctrl[CTRL_NPRIV_BIT];
  assign use_proc   = !in_handler && ctrl[CTRL_SPSEL_BIT];
  assign ex_op      = pipe_op[PIPE_STAGES-1];
  assign ex_data    = pipe_data[PIPE_STAGES-1];
  assign ex_vld     = pipe_vld[PIPE_STAGES-1] && (state inside {CMPS_THREAD, CMPS_HANDLER});
  assign sp_dec     = (use_proc ? proc_sp : main_sp) - WORD_BYTES;

  // ************************************************************
  // three-stage pipe: fetch, decode, execute
  // ************************************************************
  // stage 0 takes the inputs, every later stage the one before it
  genvar g;
  generate
    for (g = 0; g < PIPE_STAGES; g++) begin : g_pipe
      if (g == 0) begin : g_first
        assign next_pipe_op[g]   = instr_op_in;
        assign next_pipe_data[g] = instr_data_in;
        assign next_pipe_vld[g]  = instr_valid_in;
      end else begin : g_next
        assign next_pipe_op[g]   = pipe_op[g-1];
        assign next_pipe_data[g] = pipe_data[g-1];
        assign next_pipe_vld[g]  = pipe_vld[g-1];
      end
    end
  endgenerate

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe_op[i]   <= CMPS_OP_NONE;
        pipe_data[i] <= '0;
        pipe_vld[i]  <= 1'b0;
      end
    end else begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe_op[i]   <= next_pipe_op[i];
        pipe_data[i] <= next_pipe_data[i];
        pipe_vld[i]  <= next_pipe_vld[i];
      end
    end
  end

  // ************************************************************
  // next-state logic
  // ************************************************************
  // a push writes at the decremented pointer and keeps that address
  always_comb begin
    next_state   = state;
    next_ctrl    = ctrl;
    next_main_sp = main_sp;
    next_proc_sp = proc_sp;
    next_rd      = 1'b0;
    next_wr      = 1'b0;
    next_addr    = dmem_addr_out;
    next_wdata   = dmem_wdata_out;
    next_fault   = 1'b0;
    next_svc     = 1'b0;
    next_sreg    = sreg_data_out;
    unique case (state)
      CMPS_BOOT: begin
        // fetch the initial main pointer before any instruction acts
        next_rd    = 1'b1;
        next_addr  = SP_VECTOR_ADDR;
        next_state = CMPS_LOADSP;
      end
      CMPS_LOADSP: begin
        next_main_sp = dmem_rdata_in;
        next_state   = CMPS_THREAD;
      end
      CMPS_THREAD, CMPS_HANDLER: begin
        if (ex_vld) begin
          unique case (ex_op)
            CMPS_OP_CTRL_WR: begin
              if (priv) begin
                next_ctrl = ex_data[1:0];
              end else begin
                next_fault = 1'b1;
              end
            end
            CMPS_OP_SREG_WR, CMPS_OP_STATE_CHG, CMPS_OP_SYS_ACC: begin
              next_fault = !priv;
            end
            CMPS_OP_SREG_RD: begin
              next_sreg = priv ? {30'h0, ctrl} : '0;
            end
            CMPS_OP_SUP_CALL: begin
              next_svc = 1'b1;
            end
            CMPS_OP_PUSH: begin
              next_wr    = 1'b1;
              next_addr  = sp_dec;
              next_wdata = ex_data;
              if (use_proc) begin
                next_proc_sp = sp_dec;
              end else begin
                next_main_sp = sp_dec;
              end
            end
            CMPS_OP_NONE: begin
            end
          endcase
        end
        // entry is ignored in handler mode: no nesting is tracked
        if (state == CMPS_THREAD && exc_entry_in) begin
          next_state = CMPS_HANDLER;
        end else if (state == CMPS_HANDLER && exc_return_in) begin
          next_state = CMPS_THREAD;
        end
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state            <= CMPS_BOOT;
      ctrl             <= CTRL_RESET;
      main_sp          <= SP_RESET;
      proc_sp          <= SP_RESET;
      dmem_read_out    <= 1'b0;
      dmem_write_out   <= 1'b0;
      dmem_addr_out    <= ADDR_RESET;
      dmem_wdata_out   <= '0;
      imem_fetch_out   <= 1'b0;
      handler_mode_out <= 1'b0;
      privileged_out   <= 1'b1;
      proc_stack_out   <= 1'b0;
      control_out      <= CTRL_RESET;
      main_sp_out      <= SP_RESET;
      process_sp_out   <= SP_RESET;
      fault_out        <= 1'b0;
      svc_request_out  <= 1'b0;
      sreg_data_out    <= '0;
    end else begin
      state            <= next_state;
      ctrl             <= next_ctrl;
      main_sp          <= next_main_sp;
      proc_sp          <= next_proc_sp;
      dmem_read_out    <= next_rd;
      dmem_write_out   <= next_wr;
      dmem_addr_out    <= next_addr;
      dmem_wdata_out   <= next_wdata;
      imem_fetch_out   <= (next_state inside {CMPS_THREAD, CMPS_HANDLER});
      handler_mode_out <= (next_state == CMPS_HANDLER);
      privileged_out   <= (next_state == CMPS_HANDLER) || !next_ctrl[CTRL_NPRIV_BIT];
      proc_stack_out   <= (next_state != CMPS_HANDLER) && next_ctrl[CTRL_SPSEL_BIT];
      control_out      <= next_ctrl;
      main_sp_out      <= next_main_sp;
      process_sp_out   <= next_proc_sp;
      fault_out        <= next_fault;
      svc_request_out  <= next_svc;
      sreg_data_out    <= next_sreg;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  // mode changes
  a_boot_to_thread: assert property (@(posedge clk_in) disable iff (reset_in)
    $past(state) == CMPS_LOADSP |-> state == CMPS_THREAD)
    else $error("reset did not end in thread mode");

  a_handler_is_priv: assert property (@(posedge clk_in) disable iff (reset_in)
    handler_mode_out |-> privileged_out && !proc_stack_out)
    else $error("handler mode not privileged on main stack");

  a_exc_entry: assert property (@(posedge clk_in) disable iff (reset_in)
    state == CMPS_THREAD && exc_entry_in |=> handler_mode_out)
    else $error("exception entry did not reach handler mode");

  a_exc_return: assert property (@(posedge clk_in) disable iff (reset_in)
    state == CMPS_HANDLER && exc_return_in |=> !handler_mode_out)
    else $error("exception return did not reach thread mode");

  // privilege gate
  a_unpriv_ctrl: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && !priv && ex_op == CMPS_OP_CTRL_WR |=> $stable(ctrl) && fault_out)
    else $error("unprivileged control write took effect");

  a_priv_ctrl: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && priv && ex_op == CMPS_OP_CTRL_WR |=> ctrl == $past(ex_data[1:0]))
    else $error("privileged control write lost");

  a_restricted_op: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && ex_op inside {CMPS_OP_STATE_CHG, CMPS_OP_SYS_ACC} |=>
      fault_out == !$past(priv))
    else $error("privilege gate wrong for restricted operation");

  a_priv_no_fault: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && priv |=> !fault_out)
    else $error("privileged operation refused");

  a_unpriv_sreg_rd: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && !priv && ex_op == CMPS_OP_SREG_RD |=> sreg_data_out == '0)
    else $error("unprivileged special read returned data");

  a_priv_sreg_rd: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && priv && ex_op == CMPS_OP_SREG_RD |=> sreg_data_out == {30'h0, $past(ctrl)})
    else $error("privileged special read wrong");

  a_super_call: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && ex_op == CMPS_OP_SUP_CALL |=> svc_request_out)
    else $error("supervisor call not raised");

  // stacks
  a_push_desc: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && ex_op == CMPS_OP_PUSH |=>
      dmem_write_out && dmem_addr_out == $past(sp_dec) &&
      ($past(use_proc) ? process_sp_out : main_sp_out) == dmem_addr_out)
    else $error("push did not pre-decrement the stack pointer");

  a_no_stray_write: assert property (@(posedge clk_in) disable iff (reset_in)
    !(ex_vld && ex_op == CMPS_OP_PUSH) |=> !dmem_write_out)
    else $error("memory write without a push");

  a_push_main_only: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && ex_op == CMPS_OP_PUSH && !use_proc |=> $stable(proc_sp))
    else $error("main stack push moved the process pointer");

  a_push_proc_only: assert property (@(posedge clk_in) disable iff (reset_in)
    ex_vld && ex_op == CMPS_OP_PUSH && use_proc |=> $stable(main_sp))
    else $error("process stack push moved the main pointer");

  // reset-time pointer load
  a_reset_read: assert property (@(posedge clk_in) disable iff (reset_in)
    state == CMPS_BOOT |=> dmem_read_out && dmem_addr_out == SP_VECTOR_ADDR)
    else $error("initial pointer read not issued");

  a_sp_load: assert property (@(posedge clk_in) disable iff (reset_in)
    state == CMPS_LOADSP |=> main_sp == $past(dmem_rdata_in))
    else $error("main stack pointer not loaded at reset");
endmodule

/* src/cmps_pkg.sv */
// Purpose: constants for the core mode, privilege and stack unit
// Assumes: one 20 MHz clock, asynchronous active-high reset
// Notes: control word layout follows the core control register
package cmps_pkg;
  localparam int          DATA_W         = 32;
  localparam int          CTRL_NPRIV_BIT = 0;
  localparam int          CTRL_SPSEL_BIT = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [31:0] SP_VECTOR_ADDR = 32'h0000_0000;
  localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
  localparam logic [31:0] SP_RESET       = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET     = 32'h0000_0000;
  localparam int          PIPE_STAGES    = 3;
  // instruction classes seen by the execute stage
  typedef enum logic [2:0] {
    CMPS_OP_NONE, CMPS_OP_SREG_RD, CMPS_OP_CTRL_WR, CMPS_OP_SREG_WR, CMPS_OP_STATE_CHG,
    CMPS_OP_SUP_CALL, CMPS_OP_PUSH, CMPS_OP_SYS_ACC
  } cmps_op_t;
  typedef enum logic [1:0] {CMPS_BOOT, CMPS_LOADSP, CMPS_THREAD, CMPS_HANDLER} cmps_state_t;
endpackage
